// [fpec_pkg.sv]
package fpec_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [15:0] ADDR_MODE_CTRL    = 16'hFF80;
	localparam logic [15:0] ADDR_LARGE_BLOCK  = 16'hFF82;
	localparam logic [15:0] ADDR_SMALL_BLOCK  = 16'hFF83;
	localparam logic [15:0] ADDR_WAIT_OVERLAY = 16'hFFC2;
	localparam logic [15:0] ADDR_BOOT_STATUS  = 16'hFFD0;
	localparam logic [15:0] ADDR_BOOT_LOW_LO  = 16'hFFD1;
	localparam logic [15:0] ADDR_BOOT_LOW_MID = 16'hFFD2;
	localparam logic [15:0] ADDR_BOOT_LOW_HI  = 16'hFFD3;

	// ------------------------------------------------------------
	// Reset values and fixed read patterns
	// ------------------------------------------------------------
	localparam logic [7:0] RST_MODE_CTRL    = 8'h00;
	localparam logic [7:0] RST_LARGE_BLOCK  = 8'hF0;
	localparam logic [7:0] RST_SMALL_BLOCK  = 8'h00;
	localparam logic [7:0] RST_WAIT_OVERLAY = 8'h08;
	localparam logic [7:0] READ_ALL_ONES    = 8'hFF;
	localparam logic [7:0] READ_UNMAPPED    = 8'h00;
	localparam logic [3:0] LARGE_FIXED_HIGH = 4'hF;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int BIT_VPP_FLAG     = 7;
	localparam int BIT_ERASE_VERIFY = 3;
	localparam int BIT_PROG_VERIFY  = 2;
	localparam int BIT_ERASE        = 1;
	localparam int BIT_PROGRAM      = 0;
	localparam int BIT_OVL_UPPER    = 7;
	localparam int BIT_OVL_LOWER    = 6;
	localparam int BIT_CLK_HALVING  = 5;
	localparam int LSB_WAIT_MODE    = 2;
	localparam int LSB_WAIT_COUNT   = 0;

	// ------------------------------------------------------------
	// Memory map
	// ------------------------------------------------------------
	localparam logic [15:0] FLASH_TOP      = 16'h7FFF;
	localparam logic [15:0] OVL_FLASH_BASE = 16'h0080;
	localparam logic [15:0] OVL_SMALL_TOP  = 16'h00FF;
	localparam logic [15:0] OVL_LARGE_TOP  = 16'h017F;
	localparam logic [15:0] OVL_RAM_OFFSET = 16'hFC00;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int READ_STATES   = 2;
	localparam int CLK_HZ        = 40_000_000;
	localparam int BOOT_MAX_BPS  = 9600;
	localparam int BOOT_LOW_BITS = 9;
	localparam int BOOT_MIN_LOW_CYC = (BOOT_LOW_BITS * CLK_HZ + BOOT_MAX_BPS - 1) / BOOT_MAX_BPS;
	localparam logic [2:0] STRAP_SETTLE = 3'h5;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_ILLEGAL = 2'b00,
		MODE_EXT     = 2'b01,
		MODE_FLASH_A = 2'b10,
		MODE_FLASH_B = 2'b11
	} fpec_mode_t;

	typedef enum logic [2:0] {
		BOOT_OFF     = 3'b000,
		BOOT_IDLE    = 3'b001,
		BOOT_MEASURE = 3'b010,
		BOOT_REPLY   = 3'b011,
		BOOT_DONE    = 3'b100,
		BOOT_FAIL    = 3'b101
	} fpec_boot_t;

endpackage

// [fpec_sync3.sv]
`timescale 1ns/100ps
module fpec_sync3 #(
	parameter int  WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input  wire logic             clk_sys,
	input  wire logic             rst_b,
	input  wire logic [WIDTH-1:0] pinIn,
	output logic      [WIDTH-1:0] stableOut
);

	// ------------------------------------------------------------
	// Three stages; a bit moves only when the last two agree.
	// ------------------------------------------------------------
	logic [WIDTH-1:0] stage1Reg;
	logic [WIDTH-1:0] stage2Reg;
	logic [WIDTH-1:0] stage3Reg;
	logic [WIDTH-1:0] stable_next;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			assign stable_next[i] = (stage2Reg[i] == stage3Reg[i]) ? stage3Reg[i] : stableOut[i];
		end
	endgenerate

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			stage1Reg <= INIT;
			stage2Reg <= INIT;
			stage3Reg <= INIT;
			stableOut <= INIT;
		end else begin
			stage1Reg <= pinIn;
			stage2Reg <= stage1Reg;
			stage3Reg <= stage2Reg;
			stableOut <= stable_next;
		end
	end

endmodule

// [fpec_top.sv]
`timescale 1ns/100ps
module fpec_top #(
	parameter int BOOT_MIN_LOW_CYC = fpec_pkg::BOOT_MIN_LOW_CYC,
	parameter int LOW_CNT_W        = 18
) (
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	input  wire logic        modePinUpper,
	input  wire logic        modePinLower,
	input  wire logic        programmingVoltagePin,
	input  wire logic        bootSelectPin,
	input  wire logic        bootSerialRxd,
	input  wire logic        softStandby,
	input  wire logic        hardStandby,
	input  wire logic [15:0] regAddr,
	input  wire logic [7:0]  regWrData,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic      [7:0]  regRdData,
	input  wire logic [15:0] cpuAddr,
	input  wire logic        cpuRd,
	input  wire logic        cpuWord,
	input  wire logic [15:0] flashRdData,
	output logic      [15:0] cpuRdData,
	output logic             cpuRdDone,
	output logic             flashAreaSel,
	output logic             extAreaSel,
	output logic             overlayRamSel,
	output logic      [15:0] mappedAddr,
	output logic             illegalMode,
	output logic             programEn,
	output logic             eraseEn,
	output logic             programVerifyEn,
	output logic             eraseVerifyEn,
	output logic      [3:0]  largeBlockEn,
	output logic      [7:0]  smallBlockEn,
	output logic             peripheralClockHalving,
	output logic      [1:0]  waitModeSelect,
	output logic      [1:0]  waitCount,
	output logic             bootSerialTxd,
	output logic             bootActive,
	output logic             bootAligned
);

	// ------------------------------------------------------------
	// Pin synchronisation
	// ------------------------------------------------------------
	logic [4:0] pinSync;
	logic       modeUpper;
	logic       modeLower;
	logic       progVoltagePresent;
	logic       bootSel;
	logic       rxd;

	fpec_sync3 #(
		.WIDTH (5),
		.INIT  (5'h01)
	) u_sync (
		.clk_sys   (clk_sys),
		.rst_b     (rst_b),
		.pinIn     ({modePinUpper, modePinLower, programmingVoltagePin, bootSelectPin,
		             bootSerialRxd}),
		.stableOut (pinSync)
	);

	assign {modeUpper, modeLower, progVoltagePresent, bootSel, rxd} = pinSync;

	// ------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------
	fpec_pkg::fpec_mode_t memMode;
	logic flashOn;
	logic flashClear;

	assign memMode    = fpec_pkg::fpec_mode_t'({modeUpper, modeLower});
	assign flashOn    = modeUpper;
	assign flashClear = softStandby || hardStandby || !progVoltagePresent;

	// ------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------
	logic [3:0] modeSelReg;
	logic [3:0] modeSel_next;
	logic [3:0] largeReg;
	logic [3:0] large_next;
	logic [7:0] smallReg;
	logic [7:0] small_next;
	logic [7:0] waitOvlReg;
	logic [7:0] waitOvl_next;
	logic       wrMode;
	logic       wrLarge;
	logic       wrSmall;
	logic       wrWait;
	logic [7:0] modeView;
	logic [7:0] largeView;
	logic [7:0] smallView;
	logic [7:0] rd_next;

	assign wrMode  = regWr && (regAddr == fpec_pkg::ADDR_MODE_CTRL);
	assign wrLarge = regWr && (regAddr == fpec_pkg::ADDR_LARGE_BLOCK);
	assign wrSmall = regWr && (regAddr == fpec_pkg::ADDR_SMALL_BLOCK);
	assign wrWait  = regWr && (regAddr == fpec_pkg::ADDR_WAIT_OVERLAY);

	assign modeSel_next = flashClear ? fpec_pkg::RST_MODE_CTRL[3:0] :
	                      (wrMode && flashOn) ? regWrData[3:0] : modeSelReg;
	assign large_next   = flashClear ? fpec_pkg::RST_LARGE_BLOCK[3:0] :
	                      (wrLarge && flashOn) ? regWrData[3:0] : largeReg;
	assign small_next   = flashClear ? fpec_pkg::RST_SMALL_BLOCK :
	                      (wrSmall && flashOn) ? regWrData : smallReg;
	assign waitOvl_next = hardStandby ? fpec_pkg::RST_WAIT_OVERLAY :
	                      wrWait ? regWrData : waitOvlReg;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			modeSelReg <= fpec_pkg::RST_MODE_CTRL[3:0];
			largeReg   <= fpec_pkg::RST_LARGE_BLOCK[3:0];
			smallReg   <= fpec_pkg::RST_SMALL_BLOCK;
			waitOvlReg <= fpec_pkg::RST_WAIT_OVERLAY;
		end else begin
			modeSelReg <= modeSel_next;
			largeReg   <= large_next;
			smallReg   <= small_next;
			waitOvlReg <= waitOvl_next;
		end
	end

	// Live voltage flag; zero bits; reset shows 80 with voltage.
	assign modeView  = flashOn ? {progVoltagePresent, 3'h0, modeSelReg} : fpec_pkg::READ_ALL_ONES;
	assign largeView = flashOn ? {fpec_pkg::LARGE_FIXED_HIGH, largeReg} : fpec_pkg::READ_ALL_ONES;
	assign smallView = flashOn ? smallReg : fpec_pkg::READ_ALL_ONES;

	// ------------------------------------------------------------
	// Boot rate alignment
	// ------------------------------------------------------------
	fpec_pkg::fpec_boot_t bootStateReg;
	fpec_pkg::fpec_boot_t bootState_next;
	logic [LOW_CNT_W-1:0] lowCntReg;
	logic [LOW_CNT_W-1:0] lowCnt_next;
	logic [LOW_CNT_W-1:0] replyCntReg;
	logic [LOW_CNT_W-1:0] replyCnt_next;
	logic                 strapTakenReg;
	logic [2:0]           strapCntReg;
	logic                 strapDue;
	logic                 lowTooShort;

	// The strap pins are only trusted once the pin synchroniser has filled.
	assign strapDue = strapCntReg == fpec_pkg::STRAP_SETTLE;

	// The reply byte of zeros with its start bit is nine low bit times, the
	// same span the host just sent, so the measured count is replayed directly.
	assign lowTooShort = lowCntReg < LOW_CNT_W'(BOOT_MIN_LOW_CYC);

	always_comb begin
		bootState_next = bootStateReg;
		lowCnt_next    = lowCntReg;
		replyCnt_next  = replyCntReg;
		case (bootStateReg)
			fpec_pkg::BOOT_OFF: begin
				bootState_next = fpec_pkg::BOOT_OFF;
			end
			// Wait for the host start bit.
			fpec_pkg::BOOT_IDLE: begin
				if (!rxd) begin
					bootState_next = fpec_pkg::BOOT_MEASURE;
					lowCnt_next    = LOW_CNT_W'(1);
				end
			end
			fpec_pkg::BOOT_MEASURE: begin
				if (rxd) begin
					bootState_next = lowTooShort ? fpec_pkg::BOOT_FAIL : fpec_pkg::BOOT_REPLY;
					replyCnt_next  = lowCntReg - LOW_CNT_W'(1);
				end else if (lowCntReg != '1) begin
					lowCnt_next = lowCntReg + LOW_CNT_W'(1);
				end
			end
			fpec_pkg::BOOT_REPLY: begin
				if (replyCntReg == '0) begin
					bootState_next = fpec_pkg::BOOT_DONE;
				end else begin
					replyCnt_next = replyCntReg - LOW_CNT_W'(1);
				end
			end
			fpec_pkg::BOOT_DONE: begin
				bootState_next = fpec_pkg::BOOT_DONE;
			end
			fpec_pkg::BOOT_FAIL: begin
				bootState_next = fpec_pkg::BOOT_FAIL;
			end
			default: begin
				bootState_next = fpec_pkg::BOOT_OFF;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			strapCntReg   <= 3'h0;
			strapTakenReg <= 1'b0;
			bootStateReg  <= fpec_pkg::BOOT_OFF;
			lowCntReg     <= '0;
			replyCntReg   <= '0;
		end else begin
			if (!strapTakenReg) begin
				strapCntReg   <= strapCntReg + 3'h1;
				strapTakenReg <= strapDue;
				bootStateReg  <= (strapDue && bootSel && flashOn && progVoltagePresent) ?
				                 fpec_pkg::BOOT_IDLE : fpec_pkg::BOOT_OFF;
			end else begin
				bootStateReg <= bootState_next;
			end
			lowCntReg   <= lowCnt_next;
			replyCntReg <= replyCnt_next;
		end
	end

	// ------------------------------------------------------------
	// Register read port
	// ------------------------------------------------------------
	always_comb begin
		rd_next = fpec_pkg::READ_UNMAPPED;
		case (regAddr)
			fpec_pkg::ADDR_MODE_CTRL:    rd_next = modeView;
			fpec_pkg::ADDR_LARGE_BLOCK:  rd_next = largeView;
			fpec_pkg::ADDR_SMALL_BLOCK:  rd_next = smallView;
			fpec_pkg::ADDR_WAIT_OVERLAY: rd_next = waitOvlReg;
			fpec_pkg::ADDR_BOOT_STATUS:  rd_next = {5'h00, bootStateReg};
			fpec_pkg::ADDR_BOOT_LOW_LO:  rd_next = lowCntReg[7:0];
			fpec_pkg::ADDR_BOOT_LOW_MID: rd_next = lowCntReg[15:8];
			fpec_pkg::ADDR_BOOT_LOW_HI:  rd_next = 8'(lowCntReg[LOW_CNT_W-1:16]);
			default:                     rd_next = fpec_pkg::READ_UNMAPPED;
		endcase
	end

	// ------------------------------------------------------------
	// Memory map and flash read path
	// ------------------------------------------------------------
	logic [1:0]  ovlSel;
	logic        inFlashArea;
	logic        ovlHit;
	logic        rdPendReg;
	logic        rdWordReg;
	logic        rdOddReg;
	logic [15:0] rdData_next;

	assign ovlSel = {waitOvlReg[fpec_pkg::BIT_OVL_UPPER], waitOvlReg[fpec_pkg::BIT_OVL_LOWER]};
	assign inFlashArea = cpuAddr <= fpec_pkg::FLASH_TOP;
	assign ovlHit = flashOn && (cpuAddr >= fpec_pkg::OVL_FLASH_BASE) &&
	                (((ovlSel == 2'b01) && (cpuAddr <= fpec_pkg::OVL_SMALL_TOP)) ||
	                 ((ovlSel == 2'b10) && (cpuAddr <= fpec_pkg::OVL_LARGE_TOP)));
	// Word whole, byte from its lane in the low byte.
	assign rdData_next = rdWordReg ? flashRdData :
	                     {8'h00, (rdOddReg ? flashRdData[7:0] : flashRdData[15:8])};

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rdPendReg     <= 1'b0;
			rdWordReg     <= 1'b0;
			rdOddReg      <= 1'b0;
			flashAreaSel  <= 1'b0;
			extAreaSel    <= 1'b0;
			overlayRamSel <= 1'b0;
			mappedAddr    <= 16'h0000;
			cpuRdDone     <= 1'b0;
			cpuRdData     <= 16'h0000;
			illegalMode   <= 1'b0;
		end else begin
			rdPendReg   <= cpuRd;
			cpuRdDone   <= rdPendReg;
			illegalMode <= (memMode == fpec_pkg::MODE_ILLEGAL);
			if (cpuRd) begin
				rdWordReg <= cpuWord;
				rdOddReg  <= cpuAddr[0];
				// Route to flash, external memory or overlay RAM.
				flashAreaSel  <= inFlashArea && flashOn && !ovlHit;
				extAreaSel    <= inFlashArea && (memMode == fpec_pkg::MODE_EXT);
				overlayRamSel <= inFlashArea && ovlHit;
				mappedAddr    <= ovlHit ? (cpuAddr + fpec_pkg::OVL_RAM_OFFSET) : cpuAddr;
			end
			if (rdPendReg) begin
				cpuRdData <= rdData_next;
			end
		end
	end

	// ------------------------------------------------------------
	// Control outputs
	// ------------------------------------------------------------
	logic workActive;

	// Block enables live only while programming or erasing.
	assign workActive = progVoltagePresent && flashOn &&
	                    (modeSelReg[fpec_pkg::BIT_PROGRAM] || modeSelReg[fpec_pkg::BIT_ERASE]);

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			regRdData              <= 8'h00;
			programEn              <= 1'b0;
			eraseEn                <= 1'b0;
			programVerifyEn        <= 1'b0;
			eraseVerifyEn          <= 1'b0;
			largeBlockEn           <= 4'h0;
			smallBlockEn           <= 8'h00;
			peripheralClockHalving <= 1'b0;
			waitModeSelect         <= 2'h2;
			waitCount              <= 2'h0;
			bootSerialTxd          <= 1'b1;
			bootActive             <= 1'b0;
			bootAligned            <= 1'b0;
		end else begin
			regRdData <= regRd ? rd_next : 8'h00;
			// Mode bits drive modes; voltage gates program and erase.
			programEn       <= modeSelReg[fpec_pkg::BIT_PROGRAM] && progVoltagePresent && flashOn;
			eraseEn         <= modeSelReg[fpec_pkg::BIT_ERASE] && progVoltagePresent && flashOn;
			programVerifyEn <= modeSelReg[fpec_pkg::BIT_PROG_VERIFY] && flashOn;
			eraseVerifyEn   <= modeSelReg[fpec_pkg::BIT_ERASE_VERIFY] && flashOn;
			// Large block enables; small block enables.
			largeBlockEn <= workActive ? largeReg : 4'h0;
			smallBlockEn <= workActive ? smallReg : 8'h00;
			// Clock and wait-state fields; bit four only stored.
			peripheralClockHalving <= waitOvlReg[fpec_pkg::BIT_CLK_HALVING];
			waitModeSelect         <= waitOvlReg[fpec_pkg::LSB_WAIT_MODE +: 2];
			waitCount              <= waitOvlReg[fpec_pkg::LSB_WAIT_COUNT +: 2];
			// Reply drives the transmit pin low for the measured span.
			bootSerialTxd <= (bootState_next != fpec_pkg::BOOT_REPLY);
			bootActive    <= (bootStateReg != fpec_pkg::BOOT_OFF);
			bootAligned   <= (bootStateReg == fpec_pkg::BOOT_DONE);
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	a_mode_clears: assert property (@(posedge clk_sys) disable iff (!rst_b)
		flashClear |=> (modeSelReg == 4'h0) && (smallReg == 8'h00))
		else $error("mode control not cleared");
	a_vpp_flag_read: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(regRd && regAddr == fpec_pkg::ADDR_MODE_CTRL && flashOn)
		|=> regRdData[7] == $past(progVoltagePresent))
		else $error("voltage flag misread");
	a_reserved_zero: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(regRd && regAddr == fpec_pkg::ADDR_MODE_CTRL && flashOn) |=> regRdData[6:4] == 3'h0)
		else $error("reserved bits nonzero");
	a_disabled_ones: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(regRd && !flashOn && regAddr == fpec_pkg::ADDR_SMALL_BLOCK) |=> regRdData == 8'hFF)
		else $error("disabled flash register not FF");
	a_large_upper: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(regRd && regAddr == fpec_pkg::ADDR_LARGE_BLOCK) |=> regRdData[7:4] == 4'hF)
		else $error("large block upper nibble not ones");
	a_read_two_states: assert property (@(posedge clk_sys) disable iff (!rst_b)
		cpuRd |=> ##1 cpuRdDone)
		else $error("flash read not done in two states");
	a_soft_keeps: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(softStandby && !hardStandby && !wrWait) |=> $stable(waitOvlReg))
		else $error("wait register lost in soft standby");
	a_no_prog_novpp: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!progVoltagePresent [*2] |-> !programEn && !eraseEn)
		else $error("array write without voltage");
	a_blocks_idle: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(!workActive ##1 1'b1) |-> (largeBlockEn == 4'h0) && (smallBlockEn == 8'h00))
		else $error("block enable outside work");
	a_overlay_map: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(cpuRd && flashOn && ovlSel == 2'b01 && cpuAddr == 16'h0100) |=> !overlayRamSel)
		else $error("overlay window too wide");

endmodule

// [fpec_top_tb.sv]
`timescale 1ns/100ps
module fpec_top_tb;
	typedef struct packed {
		logic        w;
		logic        fl;
		logic        ex;
		logic        ov;
		logic [15:0] ma;
		logic [15:0] d;
	} fpec_exp_t;

	logic        clk_sys = 1'b0;
	logic        rst_b = 1'b0;
	logic        modePinUpper = 1'b1;
	logic        modePinLower = 1'b0;
	logic        programmingVoltagePin = 1'b1;
	logic        bootSelectPin = 1'b0;
	logic        bootSerialRxd = 1'b1;
	logic        softStandby = 1'b0;
	logic        hardStandby = 1'b0;
	logic [15:0] regAddr = '0;
	logic [7:0]  regWrData = '0;
	logic        regWr = 1'b0;
	logic        regRd = 1'b0;
	logic [7:0]  regRdData;
	logic [15:0] cpuAddr = '0;
	logic        cpuRd = 1'b0;
	logic        cpuWord = 1'b0;
	logic [15:0] flashRdData = '0;
	logic [15:0] cpuRdData, mappedAddr;
	logic        cpuRdDone, flashAreaSel, extAreaSel, overlayRamSel, illegalMode;
	logic        programEn, eraseEn, programVerifyEn, eraseVerifyEn, peripheralClockHalving;
	logic [3:0]  largeBlockEn;
	logic [7:0]  smallBlockEn;
	logic [1:0]  waitModeSelect, waitCount;
	logic        rdPend = 1'b0;
	logic [7:0]  regQ[$];
	fpec_exp_t   cpuQ[$];
	fpec_exp_t   ce;
	int          n_fail = 0;
	int          checked = 0;
	logic [7:0]  sv, wv;
	logic        bootSerialTxd, bootActive, bootAligned;
	int          nLow;

	always #12.5 clk_sys = ~clk_sys;

	fpec_top #(.BOOT_MIN_LOW_CYC(20)) fpec_top_i (.clk_sys(clk_sys), .rst_b(rst_b),
		.modePinUpper(modePinUpper), .modePinLower(modePinLower),
		.programmingVoltagePin(programmingVoltagePin), .bootSelectPin(bootSelectPin),
		.bootSerialRxd(bootSerialRxd), .softStandby(softStandby), .hardStandby(hardStandby),
		.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
		.regRdData(regRdData), .cpuAddr(cpuAddr), .cpuRd(cpuRd), .cpuWord(cpuWord),
		.flashRdData(flashRdData), .cpuRdData(cpuRdData), .cpuRdDone(cpuRdDone),
		.flashAreaSel(flashAreaSel), .extAreaSel(extAreaSel), .overlayRamSel(overlayRamSel),
		.mappedAddr(mappedAddr), .illegalMode(illegalMode), .programEn(programEn),
		.eraseEn(eraseEn), .programVerifyEn(programVerifyEn), .eraseVerifyEn(eraseVerifyEn),
		.largeBlockEn(largeBlockEn), .smallBlockEn(smallBlockEn),
		.peripheralClockHalving(peripheralClockHalving), .waitModeSelect(waitModeSelect),
		.waitCount(waitCount), .bootSerialTxd(bootSerialTxd), .bootActive(bootActive),
		.bootAligned(bootAligned));

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic tally_and_finish;
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Strobes stay up between calls so accesses run back to back; idle drops them.
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		regWr <= 1'b1;
		regRd <= 1'b0;
		regAddr <= a;
		regWrData <= d;
	endtask

	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		regWr <= 1'b0;
		regRd <= 1'b1;
		regAddr <= a;
		regQ.push_back(e);
	endtask

	task automatic idle;
		@(posedge clk_sys);
		regWr <= 1'b0;
		regRd <= 1'b0;
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask

	// Flash data is held two more edges so its sampling cycle is never in doubt.
	task automatic cr(input logic [15:0] a, input logic [1:0] ovl);
		fpec_exp_t x;
		x.w = 1'($urandom % 2);
		x.d = 16'($urandom);
		x.ov = (ovl == 2'b01 && a >= 16'h0080 && a <= 16'h00FF) ||
			(ovl == 2'b10 && a >= 16'h0080 && a <= 16'h017F);
		x.ex = !modePinUpper && modePinLower;
		x.fl = modePinUpper && !x.ov && a <= 16'h7FFF;
		x.ma = x.ov ? a + 16'hFC00 : a;
		@(posedge clk_sys);
		cpuRd <= 1'b1;
		cpuAddr <= a;
		cpuWord <= x.w;
		flashRdData <= x.d;
		if (!x.w)
			x.d = {8'h00, a[0] ? x.d[7:0] : x.d[15:8]};
		cpuQ.push_back(x);
		@(posedge clk_sys);
		cpuRd <= 1'b0;
		repeat (2) @(posedge clk_sys);
	endtask

	// ------------------------------------------------------------
	// Result monitor
	// ------------------------------------------------------------
	always @(negedge clk_sys) begin
		if (rdPend)
			chk("regRdData", {8'h00, regQ.pop_front()}, {8'h00, regRdData});
		rdPend = regRd;
		if (cpuRdDone === 1'b1) begin
			ce = cpuQ.pop_front();
			chk("cpuRdData", ce.w ? ce.d : {8'h00, ce.d[7:0]},
				ce.w ? cpuRdData : {8'h00, cpuRdData[7:0]});
			chk("areaSel", {13'h0, ce.fl, ce.ex, ce.ov},
				{13'h0, flashAreaSel, extAreaSel, overlayRamSel});
			chk("mappedAddr", ce.ma, mappedAddr);
		end
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		void'($urandom(32'hacfc));
		repeat (8) @(posedge clk_sys);
		rst_b <= 1'b1;
		settle(6);
		chk("illegalMode", 16'h0, {15'h0, illegalMode});
		chk("bootActive", 16'h0, {15'h0, bootActive});
		rd(fpec_pkg::ADDR_MODE_CTRL, 8'h80);
		rd(fpec_pkg::ADDR_LARGE_BLOCK, 8'hF0);
		rd(fpec_pkg::ADDR_SMALL_BLOCK, 8'h00);
		rd(fpec_pkg::ADDR_WAIT_OVERLAY, 8'h08);
		rd(16'hFF90, 8'h00);
		sv = 8'($urandom);
		wr(fpec_pkg::ADDR_LARGE_BLOCK, 8'h05);
		wr(fpec_pkg::ADDR_SMALL_BLOCK, sv);
		rd(fpec_pkg::ADDR_LARGE_BLOCK, 8'hF5);
		rd(fpec_pkg::ADDR_SMALL_BLOCK, sv);
		for (int i = 0; i < 4; i++) begin
			wr(fpec_pkg::ADDR_MODE_CTRL, 8'h70 | (8'h01 << i));
			rd(fpec_pkg::ADDR_MODE_CTRL, 8'h80 | (8'h01 << i));
			idle();
			settle(1);
			chk("modeEn", 16'h1 << i, {12'h0, eraseVerifyEn, programVerifyEn, eraseEn,
				programEn});
			chk("blockEn", i < 2 ? {4'h0, 4'h5, sv} : 16'h0,
				{4'h0, largeBlockEn, smallBlockEn});
		end
		wr(fpec_pkg::ADDR_MODE_CTRL, 8'h01);
		idle();
		programmingVoltagePin <= 1'b0;
		settle(6);
		chk("programEn", 16'h0, {15'h0, programEn});
		rd(fpec_pkg::ADDR_MODE_CTRL, 8'h00);
		rd(fpec_pkg::ADDR_LARGE_BLOCK, 8'hF0);
		rd(fpec_pkg::ADDR_SMALL_BLOCK, 8'h00);
		wr(fpec_pkg::ADDR_MODE_CTRL, 8'h01);
		idle();
		settle(1);
		chk("programEn", 16'h0, {15'h0, programEn});
		@(posedge clk_sys);
		programmingVoltagePin <= 1'b1;
		settle(6);
		wv = 8'($urandom);
		wr(fpec_pkg::ADDR_WAIT_OVERLAY, wv);
		wr(fpec_pkg::ADDR_MODE_CTRL, 8'h02);
		wr(fpec_pkg::ADDR_SMALL_BLOCK, 8'hFF);
		idle();
		softStandby <= 1'b1;
		idle();
		softStandby <= 1'b0;
		rd(fpec_pkg::ADDR_MODE_CTRL, 8'h80);
		rd(fpec_pkg::ADDR_SMALL_BLOCK, 8'h00);
		rd(fpec_pkg::ADDR_WAIT_OVERLAY, wv);
		idle();
		settle(1);
		chk("waitFields", {11'h0, wv[5], wv[3:0]}, {11'h0, peripheralClockHalving,
			waitModeSelect, waitCount});
		idle();
		hardStandby <= 1'b1;
		idle();
		hardStandby <= 1'b0;
		rd(fpec_pkg::ADDR_WAIT_OVERLAY, 8'h08);
		idle();
		for (int c = 0; c < 4; c++) begin
			wr(fpec_pkg::ADDR_WAIT_OVERLAY, {c[1:0], 6'h08});
			idle();
			cr(16'h0080, c[1:0]);
			cr(16'h00FF, c[1:0]);
			cr(16'h0100, c[1:0]);
			cr(16'h017F, c[1:0]);
			cr(16'h0180, c[1:0]);
			cr(16'h7FFF, c[1:0]);
			cr(16'h8000, c[1:0]);
		end
		modePinUpper <= 1'b0;
		modePinLower <= 1'b1;
		settle(6);
		wr(fpec_pkg::ADDR_MODE_CTRL, 8'h01);
		wr(fpec_pkg::ADDR_LARGE_BLOCK, 8'h00);
		rd(fpec_pkg::ADDR_MODE_CTRL, 8'hFF);
		rd(fpec_pkg::ADDR_LARGE_BLOCK, 8'hFF);
		rd(fpec_pkg::ADDR_SMALL_BLOCK, 8'hFF);
		idle();
		settle(1);
		chk("programEn", 16'h0, {15'h0, programEn});
		cr(16'h0100, 2'b11);
		modePinLower <= 1'b0;
		settle(6);
		chk("illegalMode", 16'h1, {15'h0, illegalMode});
		// Restart in boot mode; the host sends a 30-cycle low span.
		@(posedge clk_sys);
		modePinUpper <= 1'b1;
		bootSelectPin <= 1'b1;
		rst_b <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_b <= 1'b1;
		settle(10);
		chk("bootIdle", 16'h3, {14'h0, bootActive, bootSerialTxd});
		@(posedge clk_sys);
		bootSerialRxd <= 1'b0;
		repeat (30) @(posedge clk_sys);
		bootSerialRxd <= 1'b1;
		nLow = 0;
		for (int t = 0; t < 200 && bootAligned !== 1'b1; t++) begin
			@(negedge clk_sys);
			if (bootSerialTxd === 1'b0)
				nLow++;
		end
		chk("txdLow", 16'h001E, nLow[15:0]);
		chk("bootAligned", 16'h1, {15'h0, bootAligned});
		rd(fpec_pkg::ADDR_BOOT_LOW_LO, 8'h1E);
		rd(fpec_pkg::ADDR_BOOT_STATUS, 8'h04);
		idle();
		for (int t = 0; t < 20 && (regQ.size() != 0 || cpuQ.size() != 0); t++)
			@(posedge clk_sys);
		if (regQ.size() != 0 || cpuQ.size() != 0)
			n_fail++;
		tally_and_finish();
	end
endmodule
